// ---- hdl/dcct_cfg.svh ----
// Cross-trigger constants: sizes, offsets, field positions, reset values
`ifndef DCCT_CFG_SVH
`define DCCT_CFG_SVH
`define DCCT_NCH           4
`define DCCT_APP_NIN       6
`define DCCT_APP_NOUT      8
`define DCCT_NET_NIN       4
`define DCCT_NET_NOUT      2
`define DCCT_APP_OUT_USED  8'hf3
`define DCCT_NET_OUT_USED  8'h03
`define DCCT_SYNC_LAT      3
`define DCCT_AW            8
`define DCCT_OFF_APP_CTRL  8'h00
`define DCCT_OFF_NET_CTRL  8'h04
`define DCCT_OFF_APP_INEN  8'h08
`define DCCT_OFF_APP_OUTEN 8'h0c
`define DCCT_OFF_NET_INEN  8'h10
`define DCCT_OFF_NET_OUTEN 8'h14
`define DCCT_OFF_PULSE     8'h18
`define DCCT_OFF_STATUS    8'h1c
`define DCCT_POS_GLB       0
`define DCCT_POS_ST_MAT    0
`define DCCT_POS_ST_APP    4
`define DCCT_POS_ST_NET    12
`define DCCT_RST_CTRL      1'b0
`define DCCT_RST_EN        32'h0
`define DCCT_RESP_OKAY     2'h0
`define DCCT_RESP_SLVERR   2'h2
`endif

// ---- hdl/dcct_pkg.sv ----
// Cross-trigger types: bus carriers and module state records
`include "dcct_cfg.svh"
package dcct_pkg;
  typedef struct packed {
    logic                   awvalid;
    logic [`DCCT_AW-1:0]    awaddr;
    logic                   wvalid;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   bready;
    logic                   arvalid;
    logic [`DCCT_AW-1:0]    araddr;
    logic                   rready;
  } dcct_axi_req_t;
  typedef struct packed {
    logic                   awready;
    logic                   wready;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
  } dcct_axi_rsp_t;
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic rise;
  } dcct_sync_st_t;
  typedef struct packed {
    logic [7:0] trig_out;
  } dcct_tif_st_t;
  typedef struct packed {
    logic                   aw_got;
    logic [`DCCT_AW-1:0]    awaddr;
    logic                   w_got;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    logic                   app_glb;
    logic                   net_glb;
    logic [23:0]            app_inen;
    logic [31:0]            app_outen;
    logic [15:0]            net_inen;
    logic [7:0]             net_outen;
    logic [3:0]             pulse;
    logic [3:0]             mat;
  } dcct_top_st_t;
endpackage : dcct_pkg

// ---- hdl/dcct_sync.sv ----
// Three-stage input synchroniser with agreement filter and rise pulse
`timescale 1ns/1ns
module dcct_sync (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_pin,
  output logic      o_level,
  output logic      o_rise
);
  dcct_pkg::dcct_sync_st_t st;
  dcct_pkg::dcct_sync_st_t next_st;

  always_comb
  begin
    next_st      = st;
    next_st.s1   = i_pin;
    next_st.s2   = st.s1;
    next_st.s3   = st.s2;
    if (st.s2 == st.s3)
    begin
      next_st.lvl = st.s3;
    end
    next_st.rise = next_st.lvl & ~st.lvl;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign o_level = st.lvl;
  assign o_rise  = st.rise;
endmodule : dcct_sync

// ---- hdl/dcct_trig_if.sv ----
// One core's trigger interface: inputs to channels, channels to outputs
`timescale 1ns/1ns
`include "dcct_cfg.svh"
module dcct_trig_if #(
  parameter int         NIN  = 4,
  parameter int         NOUT = 2,
  parameter logic [7:0] USED = 8'hff
) (
  input  wire logic                        i_clk,
  input  wire logic                        i_rst_n,
  input  wire logic                        i_glb,
  input  wire logic [NIN-1:0]              i_trig_ev,
  input  wire logic [NIN*`DCCT_NCH-1:0]    i_in_en,
  input  wire logic [NOUT*`DCCT_NCH-1:0]   i_out_en,
  input  wire logic [`DCCT_NCH-1:0]        i_matrix,
  output logic      [`DCCT_NCH-1:0]        o_ch_ev,
  output logic      [NOUT-1:0]             o_trig_out
);
  dcct_pkg::dcct_tif_st_t st;
  dcct_pkg::dcct_tif_st_t next_st;
  logic [`DCCT_NCH-1:0] local_ch;
  logic [`DCCT_NCH-1:0] src_ch;

  always_comb
  begin
    local_ch = '0;
    for (int i = 0; i < NIN; i++)
    begin
      if (i_trig_ev[i])
      begin
        local_ch = local_ch | i_in_en[i*`DCCT_NCH +: `DCCT_NCH];
      end
    end
    o_ch_ev = i_glb ? local_ch : '0;
    src_ch  = local_ch | (i_glb ? i_matrix : '0);
    next_st = '0;
    for (int j = 0; j < NOUT; j++)
    begin
      next_st.trig_out[j] = USED[j] & |(i_out_en[j*`DCCT_NCH +: `DCCT_NCH] & src_ch);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign o_trig_out = st.trig_out[NOUT-1:0];
endmodule : dcct_trig_if

// ---- hdl/dcct_top.sv ----
// Dual-core cross-trigger network with register slave
//
// How it works
// - Cores can be halted and restarted together through the network.
// - Each interface routes inputs to outputs locally or through the matrix.
// - The shared matrix carries exactly four channels between both interfaces.
// - Matrix routing works only while the global route enable is set.
// - Application halt with input enable 0 on channel 0 raises channel 0.
// - Network output enable 0 on channel 0 drives network debug request.
// - Channel 1 carries network halt to application debug request.
// - Application interface has six trigger inputs: halt, watchpoints, trace events.
// - Application interface has eight outputs; indices 2 and 3 unconnected.
// - Network interface has four trigger inputs: halt and three watchpoints.
// - Network interface has two outputs: debug request and restart.
`timescale 1ns/1ns
`include "dcct_cfg.svh"
module dcct_top (
  input  wire logic                         i_clk,
  input  wire logic                         i_rst_n,
  input  wire logic [`DCCT_APP_NIN-1:0]     i_app_trig_in,
  input  wire logic [`DCCT_NET_NIN-1:0]     i_net_trig_in,
  output logic      [`DCCT_APP_NOUT-1:0]    o_app_trig_out,
  output logic      [`DCCT_NET_NOUT-1:0]    o_net_trig_out,
  input  wire dcct_pkg::dcct_axi_req_t      i_axi,
  output dcct_pkg::dcct_axi_rsp_t           o_axi
);
  dcct_pkg::dcct_top_st_t st;
  dcct_pkg::dcct_top_st_t next_st;
  logic [`DCCT_APP_NIN-1:0] app_rise;
  logic [`DCCT_NET_NIN-1:0] net_rise;
  logic [`DCCT_NCH-1:0]     app_ch;
  logic [`DCCT_NCH-1:0]     net_ch;
  logic [`DCCT_NCH-1:0]     matrix;
  logic                     aw_hs;
  logic                     w_hs;
  logic                     ar_hs;

  ////////////////////////////////////////////////////////////////////////////
  // Trigger input synchronisers

  for (genvar g = 0; g < `DCCT_APP_NIN; g++)
  begin : g_app_sync
    dcct_sync u_sync (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_pin   (i_app_trig_in[g]),
      .o_level (),
      .o_rise  (app_rise[g])
    );
  end

  for (genvar g = 0; g < `DCCT_NET_NIN; g++)
  begin : g_net_sync
    dcct_sync u_sync (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_pin   (i_net_trig_in[g]),
      .o_level (),
      .o_rise  (net_rise[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger interfaces and the shared matrix

  assign matrix = app_ch | net_ch | st.pulse;

  dcct_trig_if #(
    .NIN  (`DCCT_APP_NIN),
    .NOUT (`DCCT_APP_NOUT),
    .USED (`DCCT_APP_OUT_USED)
  ) u_app_if (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_glb      (st.app_glb),
    .i_trig_ev  (app_rise),
    .i_in_en    (st.app_inen),
    .i_out_en   (st.app_outen),
    .i_matrix   (matrix),
    .o_ch_ev    (app_ch),
    .o_trig_out (o_app_trig_out)
  );

  dcct_trig_if #(
    .NIN  (`DCCT_NET_NIN),
    .NOUT (`DCCT_NET_NOUT),
    .USED (`DCCT_NET_OUT_USED)
  ) u_net_if (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_glb      (st.net_glb),
    .i_trig_ev  (net_rise),
    .i_in_en    (st.net_inen),
    .i_out_en   (st.net_outen),
    .i_matrix   (matrix),
    .o_ch_ev    (net_ch),
    .o_trig_out (o_net_trig_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register helpers

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  function automatic logic mapped(input logic [`DCCT_AW-1:0] a);
    logic hit;
    case (a)
      `DCCT_OFF_APP_CTRL, `DCCT_OFF_NET_CTRL, `DCCT_OFF_APP_INEN,
      `DCCT_OFF_APP_OUTEN, `DCCT_OFF_NET_INEN, `DCCT_OFF_NET_OUTEN,
      `DCCT_OFF_PULSE, `DCCT_OFF_STATUS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : mapped

  function automatic logic [31:0] rd(input dcct_pkg::dcct_top_st_t s,
                                     input logic [`DCCT_AW-1:0]     a,
                                     input logic [7:0]              at,
                                     input logic [1:0]              nt);
    logic [31:0] v;
    v = '0;
    case (a)
      `DCCT_OFF_APP_CTRL:  v[`DCCT_POS_GLB] = s.app_glb;
      `DCCT_OFF_NET_CTRL:  v[`DCCT_POS_GLB] = s.net_glb;
      `DCCT_OFF_APP_INEN:  v[23:0] = s.app_inen;
      `DCCT_OFF_APP_OUTEN: v = s.app_outen;
      `DCCT_OFF_NET_INEN:  v[15:0] = s.net_inen;
      `DCCT_OFF_NET_OUTEN: v[7:0] = s.net_outen;
      `DCCT_OFF_STATUS:
      begin
        v[`DCCT_POS_ST_MAT +: 4] = s.mat;
        v[`DCCT_POS_ST_APP +: 8] = at;
        v[`DCCT_POS_ST_NET +: 2] = nt;
      end
      default: v = '0;
    endcase
    return v;
  endfunction : rd

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave and control registers

  always_comb
  begin
    o_axi         = '0;
    o_axi.awready = ~st.aw_got & ~st.bvalid;
    o_axi.wready  = ~st.w_got & ~st.bvalid;
    o_axi.bvalid  = st.bvalid;
    o_axi.bresp   = st.bresp;
    o_axi.arready = ~st.rvalid;
    o_axi.rvalid  = st.rvalid;
    o_axi.rdata   = st.rdata;
    o_axi.rresp   = st.rresp;
    aw_hs         = i_axi.awvalid & o_axi.awready;
    w_hs          = i_axi.wvalid & o_axi.wready;
    ar_hs         = i_axi.arvalid & o_axi.arready;
  end

  always_comb
  begin
    next_st       = st;
    next_st.pulse = '0;
    next_st.mat   = matrix;
    if (aw_hs)
    begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = i_axi.awaddr;
    end
    if (w_hs)
    begin
      next_st.w_got = 1'b1;
      next_st.wdata = i_axi.wdata;
      next_st.wstrb = i_axi.wstrb;
    end
    if (st.bvalid && i_axi.bready)
    begin
      next_st.bvalid = 1'b0;
    end
    if (st.aw_got && st.w_got && !st.bvalid)
    begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = mapped(st.awaddr) ? `DCCT_RESP_OKAY : `DCCT_RESP_SLVERR;
      case (st.awaddr)
        `DCCT_OFF_APP_CTRL:
        begin
          if (st.wstrb[0])
          begin
            next_st.app_glb = st.wdata[`DCCT_POS_GLB];
          end
        end
        `DCCT_OFF_NET_CTRL:
        begin
          if (st.wstrb[0])
          begin
            next_st.net_glb = st.wdata[`DCCT_POS_GLB];
          end
        end
        `DCCT_OFF_APP_INEN:
          next_st.app_inen = 24'(merge({8'h0, st.app_inen}, st.wdata, st.wstrb));
        `DCCT_OFF_APP_OUTEN:
          next_st.app_outen = merge(st.app_outen, st.wdata, st.wstrb);
        `DCCT_OFF_NET_INEN:
          next_st.net_inen = 16'(merge({16'h0, st.net_inen}, st.wdata, st.wstrb));
        `DCCT_OFF_NET_OUTEN:
          next_st.net_outen = 8'(merge({24'h0, st.net_outen}, st.wdata, st.wstrb));
        `DCCT_OFF_PULSE:
        begin
          if (st.wstrb[0])
          begin
            next_st.pulse = st.wdata[3:0];
          end
        end
        default: next_st.bresp = `DCCT_RESP_SLVERR;
      endcase
    end
    if (st.rvalid && i_axi.rready)
    begin
      next_st.rvalid = 1'b0;
    end
    if (ar_hs)
    begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd(st, i_axi.araddr, o_app_trig_out, o_net_trig_out);
      next_st.rresp  = mapped(i_axi.araddr) ? `DCCT_RESP_OKAY : `DCCT_RESP_SLVERR;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  property p_ch0_app_to_net;
    st.app_glb && st.net_glb && st.app_inen[0] && st.net_outen[0] && app_rise[0]
      |=> o_net_trig_out[0];
  endproperty
  a_ch0_app_to_net: assert property (p_ch0_app_to_net)
    else $error("channel 0 halt did not reach network debug request");

  property p_ch1_net_to_app;
    st.app_glb && st.net_glb && st.net_inen[1] && st.app_outen[1] && net_rise[0]
      |=> o_app_trig_out[0];
  endproperty
  a_ch1_net_to_app: assert property (p_ch1_net_to_app)
    else $error("channel 1 halt did not reach application debug request");

  property p_no_route_when_off;
    !st.app_glb && !st.net_glb && st.pulse == 4'h0 |-> matrix == 4'h0;
  endproperty
  a_no_route_when_off: assert property (p_no_route_when_off)
    else $error("matrix carried an event with routing disabled");

  property p_restart_both;
    st.app_glb && st.net_glb && st.pulse[2] && st.app_outen[6] && st.net_outen[6]
      |=> o_app_trig_out[1] && o_net_trig_out[1];
  endproperty
  a_restart_both: assert property (p_restart_both)
    else $error("channel 2 pulse did not restart both cores");

  property p_local_route;
    st.app_inen[7] && st.app_outen[19] && app_rise[1] |=> o_app_trig_out[4];
  endproperty
  a_local_route: assert property (p_local_route)
    else $error("local route from watchpoint to trace input failed");

  property p_unconnected_quiet;
    o_app_trig_out[3:2] == 2'h0;
  endproperty
  a_unconnected_quiet: assert property (p_unconnected_quiet)
    else $error("unconnected application outputs were driven");

  property p_one_event;
    app_rise[0] |=> !app_rise[0];
  endproperty
  a_one_event: assert property (p_one_event)
    else $error("one halt assertion gave two events");

  property p_sync_cause;
    app_rise[0] |-> $past(i_app_trig_in[0], 3) && $past(i_app_trig_in[0], 4);
  endproperty
  a_sync_cause: assert property (p_sync_cause)
    else $error("event without a stable synchronised input");

  property p_write_resp;
    st.aw_got && st.w_got && !st.bvalid |=> st.bvalid ##0 o_axi.bvalid;
  endproperty
  a_write_resp: assert property (p_write_resp)
    else $error("write response missing one cycle after address and data");

  property p_read_resp;
    ar_hs |=> o_axi.rvalid && o_axi.rresp == (mapped($past(i_axi.araddr))
      ? `DCCT_RESP_OKAY : `DCCT_RESP_SLVERR);
  endproperty
  a_read_resp: assert property (p_read_resp)
    else $error("read answer missing or wrong response code");

  c_app_halts_net: cover property (app_rise[0] ##1 o_net_trig_out[0]);
  c_net_halts_app: cover property (net_rise[0] ##1 o_app_trig_out[0]);
  c_restart: cover property (st.pulse[2] ##1 o_app_trig_out[1] && o_net_trig_out[1]);
endmodule : dcct_top

// ---- verif/dcct_core_model.sv ----
// Far-side model of both cores' halt and watchpoint trigger sources
`timescale 1ns/1ns
module dcct_core_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_req,
  input  wire logic [9:0] i_sel,
  input  wire logic [7:0] i_hold,
  output logic      [5:0] o_app_trig_in,
  output logic      [3:0] o_net_trig_in,
  output logic            o_busy
);
  logic [8:0] cnt;
  logic [9:0] sel;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt <= 9'h000;
      sel <= 10'h000;
    end
    else if (i_req)
    begin
      cnt <= {1'b0, i_hold} + 9'h002;
      sel <= i_sel;
    end
    else if (cnt != 9'h000)
      cnt <= cnt - 9'h001;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Levels high for the hold time, then two low cycles before going idle
  assign o_app_trig_in = (cnt > 9'h002) ? sel[5:0] : 6'h00;
  assign o_net_trig_in = (cnt > 9'h002) ? sel[9:6] : 4'h0;
  assign o_busy        = (cnt != 9'h000);
endmodule : dcct_core_model

// ---- verif/tb_top.sv ----
// Self-checking bench for the dual-core cross-trigger network
`timescale 1ns/1ns
module tb_top;
  logic                    i_clk;
  logic                    i_rst_n;
  logic [5:0]              app_in;
  logic [3:0]              net_in;
  logic [7:0]              app_out;
  logic [1:0]              net_out;
  dcct_pkg::dcct_axi_req_t req;
  dcct_pkg::dcct_axi_rsp_t rsp;
  logic                    m_req;
  logic [9:0]              m_sel;
  logic [7:0]              m_hold;
  logic                    m_busy;
  int                      err_count;
  int                      comparisons;
  int                      app_cnt [8];
  int                      net_cnt [2];

  dcct_top DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_app_trig_in(app_in),
    .i_net_trig_in(net_in), .o_app_trig_out(app_out), .o_net_trig_out(net_out),
    .i_axi(req), .o_axi(rsp));
  dcct_core_model cores (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(m_req), .i_sel(m_sel),
    .i_hold(m_hold), .o_app_trig_in(app_in), .o_net_trig_in(net_in), .o_busy(m_busy));

  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // Cycles each output is high, sampled mid-cycle
  always @(negedge i_clk)
  begin
    for (int k = 0; k < 8; k++)
      if (app_out[k] === 1'b1)
        app_cnt[k]++;
    for (int k = 0; k < 2; k++)
      if (net_out[k] === 1'b1)
        net_cnt[k]++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (err_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  task automatic wait_out(input string n);
    err_count++;
    $display("FAIL %s expected answer seen timeout", n);
    report_and_stop();
  endtask : wait_out

  task automatic check_word(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : check_word

  task automatic check_cnt(input string n, input int e, input int g);
    comparisons++;
    if (g != e)
    begin
      err_count++;
      $display("FAIL %s expected %0d seen %0d", n, e, g);
    end
  endtask : check_cnt

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hf;
    req.bready  <= 1'b1;
    do
    begin
      @(posedge i_clk);
      if (req.awvalid && rsp.awready === 1'b1)
        req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready === 1'b1)
        req.wvalid <= 1'b0;
      n++;
      if (n > 50)
        wait_out("bvalid");
    end while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    check_word("bresp", {30'h0, er}, {30'h0, rsp.bresp});
    @(posedge i_clk);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do
    begin
      @(posedge i_clk);
      if (req.arvalid && rsp.arready === 1'b1)
        req.arvalid <= 1'b0;
      n++;
      if (n > 50)
        wait_out("rvalid");
    end while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
    check_word($sformatf("rdata_%h", a), ed, rsp.rdata);
    check_word("rresp", {30'h0, er}, {30'h0, rsp.rresp});
    @(posedge i_clk);
  endtask : axi_read

  task automatic clear_cnt();
    app_cnt = '{default: 0};
    net_cnt = '{default: 0};
  endtask : clear_cnt

  task automatic fire(input logic [9:0] sel, input logic [7:0] hold);
    int n;
    n = 0;
    clear_cnt();
    m_req  <= 1'b1;
    m_sel  <= sel;
    m_hold <= hold;
    @(posedge i_clk);
    m_req <= 1'b0;
    do
    begin
      @(posedge i_clk);
      n++;
      if (n > 300)
        wait_out("core_model");
    end while (m_busy);
    repeat (8) @(posedge i_clk);
  endtask : fire

  task automatic expect_outs(input logic [7:0] ea, input logic [1:0] en);
    for (int k = 0; k < 8; k++)
      check_cnt($sformatf("app_out%0d", k), int'(ea[k]), app_cnt[k]);
    for (int k = 0; k < 2; k++)
      check_cnt($sformatf("net_out%0d", k), int'(en[k]), net_cnt[k]);
  endtask : expect_outs

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    for (int a = 0; a < 8; a++)
      axi_read(8'(4 * a), 32'h0, 2'h0);
    axi_write(8'h20, 32'h1, 2'h2);
    axi_read(8'h20, 32'h0, 2'h2);
    axi_write(8'h0c, 32'h12345678, 2'h0);
    axi_read(8'h0c, 32'h12345678, 2'h0);
    axi_write(8'h10, 32'hffffffff, 2'h0);
    axi_read(8'h10, 32'h0000ffff, 2'h0);
    axi_write(8'h0c, 32'h0, 2'h0);
    axi_write(8'h10, 32'h0, 2'h0);
  endtask : t_regs

  task automatic t_local();
    for (int i = 0; i < 6; i++)
    begin
      axi_write(8'h08, 32'h1 << (4 * i + i % 4), 2'h0);
      axi_write(8'h0c, 32'h1 << (16 + 5 * (i % 4)), 2'h0);
      fire(10'(1 << i), 8'h03);
      expect_outs(8'(8'h10 << (i % 4)), 2'h0);
    end
    axi_write(8'h08, 32'h0, 2'h0);
    axi_write(8'h0c, 32'h0, 2'h0);
    axi_write(8'h14, 32'ha5, 2'h0);
    for (int i = 0; i < 4; i++)
    begin
      axi_write(8'h10, 32'h1 << (5 * i), 2'h0);
      fire(10'(1 << (6 + i)), 8'h03);
      expect_outs(8'h00, 2'(1 << (i % 2)));
    end
    axi_write(8'h10, 32'h0, 2'h0);
    axi_write(8'h14, 32'h0, 2'h0);
  endtask : t_local

  task automatic t_gate();
    axi_write(8'h08, 32'h1, 2'h0);
    axi_write(8'h14, 32'h1, 2'h0);
    fire(10'h001, 8'h03);
    expect_outs(8'h00, 2'h0);
    axi_write(8'h00, 32'hffffffff, 2'h0);
    axi_read(8'h00, 32'h1, 2'h0);
    fire(10'h001, 8'h03);
    expect_outs(8'h00, 2'h0);
    axi_write(8'h04, 32'h1, 2'h0);
    fire(10'h001, 8'h03);
    expect_outs(8'h00, 2'h1);
    fire(10'h001, 8'd20);
    expect_outs(8'h00, 2'h1);
  endtask : t_gate

  task automatic t_reverse();
    axi_write(8'h10, 32'h2, 2'h0);
    axi_write(8'h0c, 32'h2, 2'h0);
    fire(10'h040, 8'h03);
    expect_outs(8'h01, 2'h0);
  endtask : t_reverse

  task automatic t_restart();
    axi_write(8'h0c, 32'h8421ff40, 2'h0);
    axi_write(8'h14, 32'h40, 2'h0);
    clear_cnt();
    axi_write(8'h18, 32'h4, 2'h0);
    repeat (8) @(posedge i_clk);
    expect_outs(8'h42, 2'h2);
    clear_cnt();
    axi_write(8'h18, 32'hb, 2'h0);
    repeat (8) @(posedge i_clk);
    expect_outs(8'hb0, 2'h0);
    axi_read(8'h18, 32'h0, 2'h0);
  endtask : t_restart

  initial
  begin
    i_rst_n     = 1'b0;
    req         = '0;
    m_req       = 1'b0;
    m_sel       = 10'h000;
    m_hold      = 8'h00;
    err_count   = 0;
    comparisons = 0;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    t_regs();
    t_local();
    t_gate();
    t_reverse();
    t_restart();
    report_and_stop();
  end
endmodule : tb_top
